// ### hw/wiper_pkg.sv
// shared constants and carrier types of the wiper controller
package wiper_pkg;
	// timing base
	localparam int CLK_PERIOD_NS  = 5;
	localparam int MS_NS          = 1000000;
	localparam int MS_CYCLES      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECOND_MS      = 1000;
	localparam int STALL_UNIT_MS  = 100;
	// washer hold thresholds in ms and extra swipe count
	localparam int WASH_MIN_MS    = 200;
	localparam int WASH_START_MS  = 300;
	localparam int WASH_LONG_MS   = 600;
	localparam int WASH_EXTRA     = 2;
	// interval limits in ms, standstill and high speed
	localparam int IV_SLOW_MIN_MS = 2600;
	localparam int IV_SLOW_MAX_MS = 18000;
	localparam int IV_FAST_MIN_MS = 1000;
	localparam int IV_FAST_MAX_MS = 10000;
	localparam int FAST_KMH       = 100;
	localparam int DWELL_MIN_MS   = 700;
	// register byte offsets
	localparam logic [7:0] SNOW_PARKS_OFS = 8'h00;
	localparam logic [7:0] SNOW_TIME_OFS  = 8'h04;
	localparam logic [7:0] STALL_TIME_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS     = 8'h0c;
	localparam logic [7:0] SPEED_OFS      = 8'h10;
	// register reset values
	localparam logic [7:0]  SNOW_PARKS_RST = 8'h04;
	localparam logic [15:0] SNOW_TIME_RST  = 16'h0bb8;
	localparam logic [7:0]  STALL_TIME_RST = 8'h32;

	typedef enum logic [1:0] {
		W_IDLE  = 2'b00,
		W_LEAVE = 2'b01,
		W_RUN   = 2'b10
	} wipe_state_t;

	// synchronised pin inputs
	typedef struct packed {
		logic speed_pulse;
		logic stalk_int;
		logic stalk_low;
		logic stalk_high;
		logic washer;
		logic park;
		logic ignition_run_feed;
		logic ignition_primary_feed;
	} pins_t;

	typedef struct packed {
		logic wiper_relay;
		logic bounce_relay_open;
	} relays_t;
endpackage

// ### hw/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	// pins in, filtered levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	if (WIDTH < 1)
	begin : g_chk
		$error("pin_sync width must be positive");
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// a change counts only once stages two and three agree
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_r.s2[i] == st_r.s3[i])
			begin
				st_nxt.level[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= '0;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.level;
endmodule

// ### hw/wiper_control_logic.sv
// wiper control: speed-dependent intermittent, washer wipe, snow bounce and stall guard
// Overview of operation
// [R01] speed is sensor pulses per one second
// [R02] keep previous second, use the larger
// [R03] run feed plus intermittent: speed-dependent interval
// [R04] at high speed interval range shrinks
// [R05] drive relay until park; short dwell holds on (never here: interval_ms stays above DWELL_MIN_MS)
// [R06] washer needs run feed; starts after 0.3 s
// [R07] hold 0.2 to 0.6 s gives one swipe
// [R08] longer hold: finish swipe plus two more
// [R09] hold under 0.2 s does nothing
// [R10] washer wiping beats intermittent wiping
// [R11] washer ignored while cranking
// [R12] too many parks in window flags bounce
// [R13] bounce opens the series park relay
// [R14] bounce ends on ignition off or stalk move
// [R15] no park within stall time declares stall
// [R16] no stall guard at low or high
// [R17] slow intermittent wipe aborts and suspends intermittent
// [R18] interval interpolates pot and speed limits
// [R19] window restarts on expiry; count clears on end
`timescale 1ns/1ps
module wiper_control_logic
	import wiper_pkg::*;
#(
	parameter int TICK_CYCLES     = MS_CYCLES,
	parameter int PULSES_FAST_KMH = 100
) (
	// clock, reset, enable
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    ce,
	// ahb-lite slave
	input  wire logic                    hsel,
	input  wire logic [7:0]              haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic      [31:0]             hrdata,
	// vehicle side pins and interval potentiometer code
	input  wire wiper_pkg::pins_t        pins,
	input  wire logic [7:0]              interval_potentiometer,
	// relay drives
	output wiper_pkg::relays_t           relays
);
	import wiper_pkg::*;

	if (TICK_CYCLES < 1 || TICK_CYCLES > 262144 || PULSES_FAST_KMH < 1)
	begin : g_chk
		$error("tick and speed scaling must be positive");
	end

	typedef struct packed {
		logic [17:0]  tick_cnt;
		logic [9:0]   sec_ms;
		logic [15:0]  pulse_cnt;
		logic [15:0]  speed_last;
		logic [15:0]  speed_prev;
		logic         pulse_prev;
		logic         park_prev;
		logic         int_prev;
		wipe_state_t  wstate;
		logic [15:0]  wipe_ms;
		logic [15:0]  int_ms;
		logic         int_suspend;
		logic         stall;
		logic [2:0]   stall_stalk;
		logic [15:0]  wash_ms;
		logic         wash_prev;
		logic [1:0]   wash_swipes;
		logic         wash_wipe;
		logic [15:0]  win_ms;
		logic [7:0]   park_cnt;
		logic         bounce;
		logic [7:0]   snow_parks;
		logic [15:0]  snow_time;
		logic [7:0]   stall_time;
		logic         dp_valid;
		logic         dp_write;
		logic [7:0]   dp_addr;
		logic [31:0]  rdata;
		relays_t      relays;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;
	pins_t      pin_lvl;

	pin_sync #(
		.WIDTH($bits(pins_t))
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.pin_in   (pins),
		.level_out(pin_lvl)
	);

	// linear blend from a toward b by f of 255
	function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
		input logic [7:0] f);
		int d;
		begin
			if (a > b)
			begin
				d = ((int'(a) - int'(b)) * int'(f)) / 255;
				lerp = 16'(int'(a) - d);
			end
			else
			begin
				d = ((int'(b) - int'(a)) * int'(f)) / 255;
				lerp = 16'(int'(a) + d);
			end
		end
	endfunction

	logic [15:0] speed_eff;
	logic [7:0]  speed_frac;
	logic [15:0] iv_lo;
	logic [15:0] iv_hi;
	logic [15:0] interval_ms;

	always_comb
	begin
		speed_eff = (st_r.speed_last > st_r.speed_prev) ? st_r.speed_last
			: st_r.speed_prev; // [R02]
		if (int'(speed_eff) >= PULSES_FAST_KMH)
		begin
			speed_frac = 8'hff; // [R04]
		end
		else
		begin
			speed_frac = 8'((int'(speed_eff) * 255) / PULSES_FAST_KMH);
		end
		iv_lo = lerp(16'(IV_SLOW_MIN_MS), 16'(IV_FAST_MIN_MS), speed_frac); // [R18]
		iv_hi = lerp(16'(IV_SLOW_MAX_MS), 16'(IV_FAST_MAX_MS), speed_frac); // [R18]
		interval_ms = lerp(iv_lo, iv_hi, interval_potentiometer); // [R03]
	end

	logic        ms_tick;
	logic        run_on;
	logic        cranking;
	logic        stalk_off;
	logic        manual;
	logic [2:0]  stalk_vec;
	logic        park_evt;
	logic        wash_held;
	logic        wipe_req;
	logic        hold_on;
	logic [15:0] stall_ms;

	always_comb
	begin
		st_nxt = st_r;
		ms_tick = (int'(st_r.tick_cnt) >= TICK_CYCLES - 1);
		run_on = pin_lvl.ignition_run_feed;
		cranking = pin_lvl.ignition_primary_feed && !run_on;
		manual = pin_lvl.stalk_low || pin_lvl.stalk_high;
		stalk_off = !manual && !pin_lvl.stalk_int;
		stalk_vec = {pin_lvl.stalk_int, pin_lvl.stalk_low, pin_lvl.stalk_high};
		park_evt = pin_lvl.park && !st_r.park_prev;
		wash_held = pin_lvl.washer && run_on && !cranking; // [R06] [R11]
		stall_ms = 16'(int'(st_r.stall_time) * STALL_UNIT_MS);
		wipe_req = 1'b0;
		st_nxt.tick_cnt = ms_tick ? '0 : st_r.tick_cnt + 18'h1;
		st_nxt.pulse_prev = pin_lvl.speed_pulse;
		st_nxt.park_prev = pin_lvl.park;
		st_nxt.int_prev = pin_lvl.stalk_int;
		st_nxt.wash_prev = wash_held;

		// speed measurement
		if (pin_lvl.speed_pulse && !st_r.pulse_prev && st_r.pulse_cnt != 16'hffff)
		begin
			st_nxt.pulse_cnt = st_r.pulse_cnt + 16'h1; // [R01]
		end
		if (ms_tick)
		begin
			st_nxt.sec_ms = st_r.sec_ms + 10'h1;
			if (int'(st_r.sec_ms) >= SECOND_MS - 1)
			begin
				st_nxt.sec_ms = '0;
				st_nxt.speed_last = st_nxt.pulse_cnt; // [R01]
				st_nxt.speed_prev = st_r.speed_last; // [R02]
				st_nxt.pulse_cnt = '0;
			end
		end

		// washer hold timing
		if (wash_held)
		begin
			if (ms_tick && st_r.wash_ms != 16'hffff)
			begin
				st_nxt.wash_ms = st_r.wash_ms + 16'h1;
			end
			if (int'(st_r.wash_ms) >= WASH_START_MS && st_r.wstate == W_IDLE
				&& !st_r.wash_wipe)
			begin
				wipe_req = 1'b1; // [R06]
				st_nxt.wash_wipe = 1'b1;
			end
		end
		else if (st_r.wash_prev)
		begin
			st_nxt.wash_ms = '0;
			if (int'(st_r.wash_ms) >= WASH_LONG_MS)
			begin
				st_nxt.wash_swipes = 2'(WASH_EXTRA); // [R08]
			end
			else if (int'(st_r.wash_ms) >= WASH_MIN_MS && !st_r.wash_wipe)
			begin
				st_nxt.wash_swipes = 2'h1; // [R07]
			end
			// a short tap only clears wash_ms and leaves wash_swipes untouched [R09]
		end

		// intermittent interval timer
		if (!pin_lvl.stalk_int || st_r.int_suspend)
		begin
			st_nxt.int_ms = '0;
		end
		else if (!st_r.int_prev)
		begin
			st_nxt.int_ms = 16'hffff;
		end
		else if (ms_tick && st_r.wstate == W_IDLE && st_r.int_ms != 16'hffff)
		begin
			st_nxt.int_ms = st_r.int_ms + 16'h1;
		end

		// wipe sequencer; washer swipes are served before the interval
		if (st_r.wstate == W_IDLE)
		begin
			if (st_r.wash_swipes != 2'h0)
			begin
				wipe_req = 1'b1; // [R10]
				st_nxt.wash_swipes = st_r.wash_swipes - 2'h1;
				st_nxt.wash_wipe = 1'b1;
			end
			else if (run_on && pin_lvl.stalk_int && !st_r.int_suspend
				&& st_r.int_ms >= interval_ms && !wash_held)
			begin
				wipe_req = 1'b1; // [R03] [R10]
				st_nxt.int_ms = '0;
			end
		end

		unique case (st_r.wstate)
			W_IDLE:
			begin
				if (wipe_req && run_on && !manual)
				begin
					st_nxt.wstate = W_LEAVE;
					st_nxt.wipe_ms = '0;
				end
			end
			W_LEAVE:
			begin
				// relay runs the motor until it has left park
				if (!pin_lvl.park)
				begin
					st_nxt.wstate = W_RUN; // [R05]
				end
			end
			W_RUN:
			begin
				if (park_evt)
				begin
					st_nxt.wstate = W_IDLE; // [R05]
					if (!wash_held)
					begin
						st_nxt.wash_wipe = 1'b0;
					end
				end
			end
			default:
			begin
				st_nxt.wstate = W_IDLE;
			end
		endcase

		// stall guard, only while a controller wipe is in W_LEAVE or W_RUN
		if (st_r.wstate != W_IDLE)
		begin
			if (ms_tick)
			begin
				st_nxt.wipe_ms = st_r.wipe_ms + 16'h1;
			end
			if (manual)
			begin
				st_nxt.wstate = W_IDLE; // [R16]
			end
			else if (st_r.wipe_ms >= stall_ms)
			begin
				st_nxt.wstate = W_IDLE; // [R15] [R17]
				st_nxt.stall = 1'b1; // [R15]
				st_nxt.stall_stalk = stalk_vec;
				st_nxt.int_suspend = 1'b1; // [R17]
				st_nxt.wash_swipes = '0;
			end
		end
		if (st_r.stall && (manual || stalk_vec != st_r.stall_stalk))
		begin
			st_nxt.stall = 1'b0; // [R15]
		end
		if (st_r.int_suspend && stalk_vec != st_r.stall_stalk)
		begin
			st_nxt.int_suspend = 1'b0; // [R17]
		end

		// snow bounce detection in a repeating window
		if (stalk_off && !st_r.bounce)
		begin
			if (ms_tick)
			begin
				st_nxt.win_ms = st_r.win_ms + 16'h1;
			end
			if (st_r.win_ms >= st_r.snow_time)
			begin
				st_nxt.win_ms = '0; // [R19]
				st_nxt.park_cnt = '0; // [R19]
			end
			else if (park_evt && st_r.park_cnt != 8'hff)
			begin
				st_nxt.park_cnt = st_r.park_cnt + 8'h1; // [R12]
			end
			if (st_r.park_cnt > st_r.snow_parks)
			begin
				st_nxt.bounce = 1'b1; // [R12]
			end
		end
		if (st_r.bounce && !stalk_off)
		begin
			st_nxt.bounce = 1'b0; // [R14]
			st_nxt.park_cnt = '0; // [R19]
			st_nxt.win_ms = '0;
		end

		// ignition off acts as a functional reset of the wiping logic
		if (!run_on)
		begin
			st_nxt.wstate = W_IDLE;
			st_nxt.wash_swipes = '0;
			st_nxt.wash_wipe = 1'b0;
			st_nxt.wash_ms = '0;
			st_nxt.stall = 1'b0; // [R15]
			st_nxt.int_suspend = 1'b0; // [R17]
			st_nxt.bounce = 1'b0; // [R14]
			st_nxt.park_cnt = '0; // [R19]
			st_nxt.win_ms = '0;
		end

		// relay kept on in W_RUN for an interval under DWELL_MIN_MS; interval_ms never gets that low
		hold_on = pin_lvl.stalk_int && !st_r.int_suspend
			&& interval_ms < 16'(DWELL_MIN_MS); // [R05]
		st_nxt.relays.wiper_relay = (st_nxt.wstate == W_LEAVE)
			|| (st_nxt.wstate == W_RUN && hold_on); // [R05]
		st_nxt.relays.bounce_relay_open = st_nxt.bounce || st_nxt.stall; // [R13] [R15]

		// ahb-lite data phase: write lands at its end, read data registered early
		if (st_r.dp_valid && st_r.dp_write)
		begin
			unique case (st_r.dp_addr)
				SNOW_PARKS_OFS: st_nxt.snow_parks = hwdata[7:0];
				SNOW_TIME_OFS:  st_nxt.snow_time = hwdata[15:0];
				STALL_TIME_OFS: st_nxt.stall_time = hwdata[7:0];
				default:        st_nxt.dp_valid = 1'b0;
			endcase
		end
		st_nxt.dp_valid = hsel && htrans[1] && hready;
		st_nxt.dp_write = hwrite;
		st_nxt.dp_addr = haddr;
		st_nxt.rdata = '0;
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			unique case (haddr)
				SNOW_PARKS_OFS: st_nxt.rdata = {24'h0, st_r.snow_parks};
				SNOW_TIME_OFS:  st_nxt.rdata = {16'h0, st_r.snow_time};
				STALL_TIME_OFS: st_nxt.rdata = {24'h0, st_r.stall_time};
				STATUS_OFS:     st_nxt.rdata = {16'h0, st_r.park_cnt, st_r.wash_swipes,
					st_r.wstate, st_r.int_suspend, st_r.stall, st_r.bounce,
					st_r.relays.wiper_relay};
				SPEED_OFS:      st_nxt.rdata = {st_r.speed_prev, st_r.speed_last};
				default:        st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= '0;
			st_r.snow_parks <= SNOW_PARKS_RST;
			st_r.snow_time <= SNOW_TIME_RST;
			st_r.stall_time <= STALL_TIME_RST;
			st_r.wstate <= W_IDLE;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	// zero wait states keep the slave simple; every access answers okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;
	assign relays = st_r.relays;
endmodule

// ### dv/wiper_chk.sv
// port checker of the wiper controller
`timescale 1ns/1ps
module wiper_chk
	import wiper_pkg::*;
(
	// clock and reset
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               ce,
	// bus
	input wire logic               hsel,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic               hready,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire logic [31:0]        hrdata,
	// pins and relays
	input wire wiper_pkg::pins_t   pins,
	input wire wiper_pkg::relays_t relays
);
	logic       rd_ph_r;
	logic [3:0] run_low_r;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// read data phase and a saturating count of run feed low cycles
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_ph_r <= 1'b0;
			run_low_r <= 4'h0;
		end
		else
		begin
			if (ce)
				rd_ph_r <= hsel && htrans[1] && hready && !hwrite;
			if (pins.ignition_run_feed)
				run_low_r <= 4'h0;
			else if (run_low_r != 4'hf)
				run_low_r <= run_low_r + 4'h1;
		end
	end
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_okay_resp: assert property (!hresp)
		else $error("hresp not okay");
	a_rdata_idle: assert property (!rd_ph_r |-> hrdata == 32'h0)
		else $error("hrdata outside read data phase");
	a_relay_needs_run: assert property (
		$rose(relays.wiper_relay) |-> run_low_r < 4'h8)
		else $error("wipe started without run feed");
	a_crank_ignored: assert property (
		pins.ignition_primary_feed && run_low_r == 4'hf |-> !relays.wiper_relay)
		else $error("wiper driven while cranking");
	a_ign_release: assert property (
		run_low_r == 4'hf |-> !relays.bounce_relay_open)
		else $error("bounce relay open with ignition off");
	a_manual_no_guard: assert property (
		(pins.stalk_low || pins.stalk_high) [*8] |->
		!relays.bounce_relay_open && !relays.wiper_relay)
		else $error("relay driven in low or high");
	a_int_starts: assert property (
		$rose(pins.stalk_int) && pins.ignition_run_feed && !pins.stalk_low
		&& !pins.stalk_high |-> ##[1:8] relays.wiper_relay)
		else $error("intermittent wipe did not start");
	cover property ($rose(relays.bounce_relay_open));
	cover property ($rose(relays.wiper_relay));
	cover property (rd_ph_r);
endmodule

// ### dv/wiper_motor.sv
// wiper motor with park cam, jam and snow push
`timescale 1ns/1ps
module wiper_motor #(
	parameter int ROT = 2500
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// drive sources and faults
	input wire logic run,
	input wire logic bounce_open,
	input wire logic stuck,
	input wire logic snow,
	// park cam
	output logic     park
);
	int   pos;
	int   snow_cnt = 0;
	logic cam;
	assign cam = pos < ROT / 16;
	// snow pushes the arm on and off the cam
	assign park = snow ? snow_cnt[5] : cam;
	always @(posedge hclk or negedge hresetn)
	begin
		snow_cnt <= snow_cnt + 1;
		if (!hresetn)
			pos <= 0;
		else if (!stuck && (run || (!cam && !bounce_open)))
			pos <= (pos + 1) % ROT;
	end
endmodule

// ### dv/tb_wiper_control_logic.sv
// testbench of the wiper controller
`timescale 1ns/1ps
module tb_wiper_control_logic;
	import wiper_pkg::*;
	typedef struct {int run; int hold; logic on; int n;} row_t;
	localparam int TICK = 5;
	// washer rows: run feed, hold ms, relay at 303 ms of hold (or at release if sooner), swipes
	row_t rows[5] = '{'{1, 100, 0, 0}, '{1, 250, 0, 1}, '{1, 400, 1, 1},
		'{1, 700, 1, 3}, '{0, 400, 0, 0}};
	logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
	logic        stuck = 0, snow = 0, park, park_d = 1, hreadyout, hresp, rdy_q;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] hwdata = 32'h0, hrdata, rd_q, q;
	pins_t       pv = '0;
	pins_t       pw;
	relays_t     relays;
	int          failures = 0, tests_run = 0, wipes = 0;
	assign pw = {pv[7:3], park, pv[1:0]};
	always #2.5 hclk = ~hclk;
	always @(posedge hclk)
	begin
		rd_q <= hrdata;
		rdy_q <= hreadyout;
		park_d <= park;
		if (park_d && !park)
			wipes++;
	end
	wiper_control_logic #(.TICK_CYCLES(TICK)) dut (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pins(pw), .interval_potentiometer(8'h80),
		.relays(relays));
	// short rotation keeps one wipe well inside the 200 ms stall time set below
	wiper_motor #(.ROT(500)) mot (.hclk(hclk), .hresetn(hresetn),
		.run(relays.wiper_relay | pv.stalk_low | pv.stalk_high),
		.bounce_open(relays.bounce_relay_open), .stuck(stuck), .snow(snow), .park(park));
	task step(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// single word transfer; waits on the captured hready
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do step(1); while (rdy_q !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do step(1); while (rdy_q !== 1'b1);
		q = rd_q;
	endtask
	// parked and relay off for 400 ms
	task settle;
		int quiet;
		quiet = 0;
		while (quiet < 2000)
		begin
			step(1);
			quiet = (relays.wiper_relay || !park) ? 0 : quiet + 1;
		end
	endtask
	task final_report;
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		step(80000);
		failures++;
		final_report();
	end
	initial
	begin
		step(10);
		hresetn <= 1'b1;
		chk("relays in reset", 32'h0, {30'h0, relays});
		pv.ignition_run_feed <= 1'b1;
		pv.ignition_primary_feed <= 1'b1;
		xfer(0, SNOW_PARKS_OFS, 0);
		chk("snow_parks", {24'h0, SNOW_PARKS_RST}, q);
		xfer(0, SNOW_TIME_OFS, 0);
		chk("snow_time", {16'h0, SNOW_TIME_RST}, q);
		xfer(0, STALL_TIME_OFS, 0);
		chk("stall_time", {24'h0, STALL_TIME_RST}, q);
		// looser park limit so washer swipes never read as bounce
		xfer(1, SNOW_PARKS_OFS, 32'h8);
		xfer(1, STALL_TIME_OFS, 32'h2);
		xfer(0, STALL_TIME_OFS, 0);
		chk("stall_time", 32'h2, q);
		xfer(1, 8'h40, 32'hff);
		xfer(0, 8'h40, 0);
		chk("unmapped", 32'h0, q);
		$display("Test registers done");
		repeat (300)
		begin
			pv.speed_pulse <= 1'b1;
			step(25);
			pv.speed_pulse <= 1'b0;
			step(25);
		end
		xfer(0, SPEED_OFS, 0);
		chk("speed", 32'h00640064, q);
		$display("Test speed done");
		foreach (rows[i])
		begin
			pv.ignition_run_feed <= rows[i].run[0];
			step(20);
			wipes = 0;
			pv.washer <= 1'b1;
			// relay stands only while the arm leaves park, so look just after 0.3 s
			step((rows[i].hold < 303 ? rows[i].hold : 303) * TICK - 1);
			chk("relay after 303 ms hold", {31'h0, rows[i].on}, {31'h0, relays.wiper_relay});
			if (rows[i].hold > 303)
				step((rows[i].hold - 303) * TICK);
			pv.washer <= 1'b0;
			settle();
			chk("swipes", rows[i].n, wipes);
			$display("Test washer row %0d done", i);
		end
		pv.ignition_run_feed <= 1'b1;
		step(20);
		snow <= 1'b1;
		for (int k = 0; k < 4000 && !relays.bounce_relay_open; k++)
			step(1);
		chk("bounce open", 32'h1, {31'h0, relays.bounce_relay_open});
		snow <= 1'b0;
		pv.stalk_low <= 1'b1;
		step(20);
		chk("bounce after low", 32'h0, {31'h0, relays.bounce_relay_open});
		pv.stalk_low <= 1'b0;
		settle();
		$display("Test snow done");
		stuck <= 1'b1;
		pv.stalk_int <= 1'b1;
		for (int k = 0; k < 2000 && !relays.bounce_relay_open; k++)
			step(1);
		step(2);
		chk("stall open", 32'h1, {31'h0, relays.bounce_relay_open});
		chk("relay after stall", 32'h0, {31'h0, relays.wiper_relay});
		xfer(0, STATUS_OFS, 0);
		chk("stall status", 32'hc, q & 32'hc);
		pv.stalk_int <= 1'b0;
		pv.stalk_low <= 1'b1;
		// jam stays longer than the stall time: low must not guard
		step(1500);
		chk("low no guard", 32'h0, {31'h0, relays.bounce_relay_open});
		pv.stalk_low <= 1'b0;
		stuck <= 1'b0;
		step(20);
		$display("Test stall done");
		final_report();
	end
endmodule
bind wiper_control_logic wiper_chk chk_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
	.relays(relays));
